// *** adcsq_map.svh ***
// Purpose: register offsets, field positions, reset values and timing counts
// Assumes: word-indexed register port, 16-bit data
// Notes:   definitions only
`ifndef ADCSQ_MAP_SVH
`define ADCSQ_MAP_SVH
`define ADCSQ_ADDR_W           4
`define ADCSQ_OFF_SEQ_CTRL     4'h0
`define ADCSQ_OFF_TIMING       4'h1
`define ADCSQ_OFF_DMA_LEN      4'h2
`define ADCSQ_OFF_AUX_SEL      4'h3
`define ADCSQ_OFF_MAIN_SEL     4'h4
`define ADCSQ_OFF_SCAN_HI      4'h5
`define ADCSQ_OFF_SCAN_LO      4'h6
`define ADCSQ_OFF_PIN_DIGITAL_SELECT_HI      4'h7
`define ADCSQ_OFF_PIN_DIGITAL_SELECT_LO      4'h8
`define ADCSQ_OFF_MODE         4'h9
`define ADCSQ_OFF_STATUS       4'ha
`define ADCSQ_RESET_WORD       16'h0000
`define ADCSQ_SEQ_WMASK        16'h0703
`define ADCSQ_SEQ_WMASK12      16'h0403
`define ADCSQ_SEQ_INCREMENT_RATE_MASK    16'h003c
`define ADCSQ_TIM_WMASK        16'h9fff
`define ADCSQ_DMA_WMASK        16'h0007
`define ADCSQ_AUX_WMASK        16'h0707
`define ADCSQ_MAIN_WMASK       16'h9f9f
`define ADCSQ_BIT_SCAN_EN      10
`define ADCSQ_BIT_BUFFER_HALF_STATUS         7
`define ADCSQ_BIT_SPLIT_BUFFER_MODE         1
`define ADCSQ_BIT_ALTERNATE_SAMPLE_MODE         0
`define ADCSQ_BIT_CONV_CLOCK_SOURCE         15
`define ADCSQ_INCREMENT_RATE_LSB         2
`define ADCSQ_AUTO_SAMPLE_TIME_LSB         8
`define ADCSQ_SAMPLE_NS        100
`define ADCSQ_CLK_NS           100
`define ADCSQ_CYC_PER_SAMPLE   \
  ((`ADCSQ_SAMPLE_NS + `ADCSQ_CLK_NS - 1) / `ADCSQ_CLK_NS)
`define ADCSQ_CONV_TAD         12
`define ADCSQ_SCAN_PTR_RST     5'h1f
`endif

// *** adcsq_pkg.sv ***
// Purpose: shared types for the converter sequence and input select block
// Assumes: adcsq_map.svh holds the numbers
// Notes:   types only
package adcsq_pkg;
  typedef enum logic [2:0] {
    ADCSQ_IDLE   = 3'b001,
    ADCSQ_SAMPLE = 3'b010,
    ADCSQ_CONV   = 3'b100
  } adcsq_state_type;
  typedef struct packed {
    logic [4:0] main_pos;
    logic       main_neg;
    logic [4:0] aux_pos_0;
    logic [4:0] aux_pos_1;
    logic [4:0] aux_pos_2;
    logic [1:0] aux_neg;
    logic       use_vref_neg;
    logic [1:0] channel_count;
  } adcsq_mux_type;
  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } adcsq_dma_type;
endpackage

// *** adcsq_core.sv ***
// Purpose: sequencing, input selection and pin mode logic of a converter
// Assumes: sample/conversion starts come from the converter core control
// Notes:   converter core, triggers and result data live outside
`timescale 1ns/1ns
`include "adcsq_map.svh"
module adcsq_core #(
  parameter int          INPUT_COUNT  = 32,
  parameter bit          SECOND_CONV  = 1'b0,
  parameter int          BUF_WORDS    = 16
) (
  input  wire logic                       mclk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic [`ADCSQ_ADDR_W-1:0]   reg_addr_i,
  input  wire logic [15:0]                reg_wdata_i,
  input  wire logic                       reg_wr_i,
  input  wire logic                       reg_rd_i,
  output logic      [15:0]                reg_rdata_o,
  input  wire logic                       start_sample_i,
  input  wire logic                       module_disable_i,
  input  wire logic [15:0]                peer_pin_digital_select_low_i,
  input  wire logic                       rc_clock_i,
  output adcsq_pkg::adcsq_mux_type        mux_o,
  output logic                            sampling_o,
  output logic                            conv_clk_en_o,
  output logic                            convert_done_o,
  output logic                            event_o,
  output adcsq_pkg::adcsq_dma_type        dma_o,
  output logic      [31:0]                pin_analog_o,
  output logic      [31:0]                port_read_en_o
);
  import adcsq_pkg::*;

  // elaboration checks on the parameters
  if (INPUT_COUNT < 1 || INPUT_COUNT > 32) begin : g_bad_count
    $error("input count must be 1 to 32");
  end
  if (BUF_WORDS < 2 || BUF_WORDS > 1024) begin : g_bad_buf
    $error("buffer words out of range");
  end

  localparam int CONV_TAD = `ADCSQ_CONV_TAD;

  // software registers
  logic [15:0] seq_ff, tim_ff, dma_len_ff, aux_ff, main_ff;
  logic [15:0] scan_hi_ff, scan_lo_ff, pin_digital_select_hi_ff, pin_digital_select_lo_ff;
  logic        twelve_bit_mode_ff;
  logic        dma_order_mode_ff;
  logic        rc_meta_ff, rc_sync_ff, rc_prev_ff;
  logic [7:0]  div_cnt_ff;
  logic [4:0]  tad_cnt_ff;
  logic [3:0]  increment_rate_cnt_ff;
  logic        half_ff;
  logic        alt_b_ff;
  logic [4:0]  scan_ptr_ff;
  logic [9:0]  buf_ptr_ff;
  logic [1:0]  ch_idx_ff;
  adcsq_state_type state_ff;
  logic        event_ff, done_ff;
  adcsq_dma_type dma_ff;
  adcsq_mux_type mux_ff;
  logic [15:0] rdata_ff;

  // write strobes per register
  wire wr_seq  = reg_wr_i && reg_addr_i == `ADCSQ_OFF_SEQ_CTRL;
  wire wr_tim  = reg_wr_i && reg_addr_i == `ADCSQ_OFF_TIMING;
  wire wr_dma  = reg_wr_i && reg_addr_i == `ADCSQ_OFF_DMA_LEN;
  wire wr_aux  = reg_wr_i && reg_addr_i == `ADCSQ_OFF_AUX_SEL;
  wire wr_main = reg_wr_i && reg_addr_i == `ADCSQ_OFF_MAIN_SEL;
  wire wr_shi  = reg_wr_i && reg_addr_i == `ADCSQ_OFF_SCAN_HI;
  wire wr_slo  = reg_wr_i && reg_addr_i == `ADCSQ_OFF_SCAN_LO;
  wire wr_phi  = reg_wr_i && reg_addr_i == `ADCSQ_OFF_PIN_DIGITAL_SELECT_HI;
  wire wr_plo  = reg_wr_i && reg_addr_i == `ADCSQ_OFF_PIN_DIGITAL_SELECT_LO;
  wire wr_mode = reg_wr_i && reg_addr_i == `ADCSQ_OFF_MODE;

  // field decode
  wire       scan_enable    = seq_ff[`ADCSQ_BIT_SCAN_EN];
  wire       split_buffer_mode = seq_ff[`ADCSQ_BIT_SPLIT_BUFFER_MODE];
  wire       alternate_sample_mode = seq_ff[`ADCSQ_BIT_ALTERNATE_SAMPLE_MODE];
  wire [3:0] increment_rate = seq_ff[`ADCSQ_INCREMENT_RATE_LSB +: 4];
  wire [1:0] channel_count_select = twelve_bit_mode_ff ? 2'b00
                                  : seq_ff[9:8];
  wire       conv_clock_source = tim_ff[`ADCSQ_BIT_CONV_CLOCK_SOURCE];
  wire [4:0] auto_sample_time  = tim_ff[`ADCSQ_AUTO_SAMPLE_TIME_LSB +: 5];
  wire [7:0] conv_clock_divider = tim_ff[7:0];
  wire [2:0] dma_buffer_length = dma_len_ff[2:0];
  wire [31:0] scan_mask = {scan_hi_ff, scan_lo_ff};
  wire [31:0] scan_masked = SECOND_CONV ? {16'h0000, scan_lo_ff}
                                        : scan_mask;
  wire [4:0] max_input = SECOND_CONV ? 5'h0f : 5'h1f;
  wire       use_b = alternate_sample_mode && alt_b_ff;
  wire [4:0] main_sel_a = main_ff[4:0];
  wire [4:0] main_sel_b = main_ff[12:8];
  wire       aux_pos_sel = use_b ? aux_ff[8] : aux_ff[0];
  wire [1:0] aux_neg_sel = use_b ? aux_ff[10:9] : aux_ff[2:1];

  // next scan slot: first set mask bit above current pointer, wraps
  logic [4:0] nxt_scan_ptr;
  logic       scan_found;
  always_comb begin
    int k;
    logic [4:0] idx;
    k            = 0;
    idx          = 5'h00;
    nxt_scan_ptr = scan_ptr_ff;
    scan_found   = 1'b0;
    for (k = 1; k <= 32; k++) begin
      idx = 5'(int'(scan_ptr_ff) + k);
      if (!scan_found && scan_masked[idx]) begin
        nxt_scan_ptr = idx;
        scan_found   = 1'b1;
      end
    end
  end

  // main positive input choice, capped on the second converter
  wire [4:0] main_raw = use_b ? main_sel_b
                      : (scan_enable ? scan_ptr_ff : main_sel_a);
  wire [4:0] main_pos = (main_raw > max_input) ? max_input
                                               : main_raw;
  wire       main_absent = int'(main_pos) >= INPUT_COUNT;
  wire       main_neg = use_b ? main_ff[15] : main_ff[7];

  // pin mode: set bit digital (low half only if the peer bit is also set), disabled module all digital
  wire [31:0] pin_digital_select_eff = {SECOND_CONV ? 16'hffff : pin_digital_select_hi_ff,
                          pin_digital_select_lo_ff & peer_pin_digital_select_low_i};
  genvar g;
  generate
    for (g = 0; g < 32; g++) begin : g_pin
      if (g < INPUT_COUNT) begin : g_real
        assign pin_analog_o[g]   = !module_disable_i && !pin_digital_select_eff[g];
        assign port_read_en_o[g] = module_disable_i || pin_digital_select_eff[g];
      end else begin : g_absent
        assign pin_analog_o[g]   = 1'b0;
        assign port_read_en_o[g] = 1'b0;
      end
    end
  endgenerate
  // applied above via pin_digital_select_eff and module_disable_i

  // conversion clock enable from cycle divider or synced rc clock
  wire div_tick = div_cnt_ff == conv_clock_divider;
  wire rc_tick  = rc_sync_ff && !rc_prev_ff;
  wire tad_en   = conv_clock_source ? rc_tick : div_tick;
  assign conv_clk_en_o = tad_en;

  // register file writes
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      seq_ff <= `ADCSQ_RESET_WORD;
      tim_ff <= `ADCSQ_RESET_WORD;
      dma_len_ff <= `ADCSQ_RESET_WORD;
      aux_ff <= `ADCSQ_RESET_WORD;
      main_ff <= `ADCSQ_RESET_WORD;
      scan_hi_ff <= `ADCSQ_RESET_WORD;
      scan_lo_ff <= `ADCSQ_RESET_WORD;
      pin_digital_select_hi_ff <= `ADCSQ_RESET_WORD;
      pin_digital_select_lo_ff <= `ADCSQ_RESET_WORD;
      twelve_bit_mode_ff <= 1'b0;
      dma_order_mode_ff <= 1'b0;
    end else begin
      if (wr_seq)
        seq_ff <= reg_wdata_i & ((twelve_bit_mode_ff ? `ADCSQ_SEQ_WMASK12
                 : `ADCSQ_SEQ_WMASK) | `ADCSQ_SEQ_INCREMENT_RATE_MASK);
      if (wr_tim)  tim_ff <= reg_wdata_i & `ADCSQ_TIM_WMASK;
      if (wr_dma)  dma_len_ff <= reg_wdata_i & `ADCSQ_DMA_WMASK;
      if (wr_aux)  aux_ff <= reg_wdata_i & `ADCSQ_AUX_WMASK;
      if (wr_main) main_ff <= reg_wdata_i & `ADCSQ_MAIN_WMASK;
      if (wr_shi)  scan_hi_ff <= reg_wdata_i;
      if (wr_slo)  scan_lo_ff <= reg_wdata_i;
      if (wr_phi)  pin_digital_select_hi_ff <= reg_wdata_i;
      if (wr_plo)  pin_digital_select_lo_ff <= reg_wdata_i;
      if (wr_mode) begin
        twelve_bit_mode_ff <= reg_wdata_i[0];
        dma_order_mode_ff  <= reg_wdata_i[1];
      end
    end
  end

  // read mux, data in the cycle after the strobe
  logic [15:0] nxt_rdata;
  always_comb begin
    case (reg_addr_i)
      `ADCSQ_OFF_SEQ_CTRL: nxt_rdata = {seq_ff[15:10], channel_count_select,
                            half_ff, seq_ff[6:0]};
      `ADCSQ_OFF_TIMING:   nxt_rdata = tim_ff;
      `ADCSQ_OFF_DMA_LEN:  nxt_rdata = dma_len_ff;
      `ADCSQ_OFF_AUX_SEL:  nxt_rdata = twelve_bit_mode_ff ? 16'h0000
                                                          : aux_ff;
      `ADCSQ_OFF_MAIN_SEL: nxt_rdata = main_ff;
      `ADCSQ_OFF_SCAN_HI:  nxt_rdata = scan_hi_ff;
      `ADCSQ_OFF_SCAN_LO:  nxt_rdata = scan_lo_ff;
      `ADCSQ_OFF_PIN_DIGITAL_SELECT_HI:  nxt_rdata = SECOND_CONV ? 16'h0000
                                                   : pin_digital_select_hi_ff;
      `ADCSQ_OFF_PIN_DIGITAL_SELECT_LO:  nxt_rdata = pin_digital_select_lo_ff;
      `ADCSQ_OFF_MODE:     nxt_rdata = {14'h0000, dma_order_mode_ff,
                                        twelve_bit_mode_ff};
      `ADCSQ_OFF_STATUS:   nxt_rdata = {11'h000, scan_ptr_ff};
      default:             nxt_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) rdata_ff <= 16'h0000;
    else if (reg_rd_i) rdata_ff <= nxt_rdata;
    else rdata_ff <= 16'h0000;
  end
  assign reg_rdata_o = rdata_ff;

  // rc clock synchroniser and cycle divider
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rc_meta_ff <= 1'b0;
      rc_sync_ff <= 1'b0;
      rc_prev_ff <= 1'b0;
      div_cnt_ff <= 8'h00;
    end else begin
      rc_meta_ff <= rc_clock_i;
      rc_sync_ff <= rc_meta_ff;
      rc_prev_ff <= rc_sync_ff;
      div_cnt_ff <= div_tick ? 8'h00 : div_cnt_ff + 8'h01;
    end
  end

  // scatter or in-order address for the dma channel
  wire [9:0] scatter_addr = 10'((int'(main_pos) << dma_buffer_length)
                          + (int'(buf_ptr_ff) & ((1 << dma_buffer_length)
                          - 1)));
  wire [9:0] half_base = (split_buffer_mode && half_ff)
                       ? 10'(BUF_WORDS / 2) : 10'h000;
  wire [9:0] order_addr = half_base + buf_ptr_ff;
  wire       last_of_group = increment_rate_cnt_ff == increment_rate;
  wire [1:0] last_ch = channel_count_select[1] ? 2'd3
                     : {1'b0, channel_count_select[0]};

  // sample, then convert each selected channel, counting in tad periods
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_ff <= ADCSQ_IDLE;
      tad_cnt_ff <= 5'h00;
      increment_rate_cnt_ff <= 4'h0;
      half_ff <= 1'b0;
      alt_b_ff <= 1'b0;
      scan_ptr_ff <= `ADCSQ_SCAN_PTR_RST;
      buf_ptr_ff <= 10'h000;
      ch_idx_ff <= 2'd0;
      event_ff <= 1'b0;
      done_ff <= 1'b0;
      dma_ff <= '0;
    end else begin
      event_ff <= 1'b0;
      done_ff <= 1'b0;
      dma_ff.req <= 1'b0;
      if (wr_slo || wr_shi || (wr_seq && !reg_wdata_i[`ADCSQ_BIT_SCAN_EN]))
        scan_ptr_ff <= `ADCSQ_SCAN_PTR_RST;
      case (state_ff)
        ADCSQ_IDLE: begin
          if (start_sample_i && !module_disable_i) begin
            state_ff <= ADCSQ_SAMPLE;
            tad_cnt_ff <= 5'h00;
            if (scan_enable && !use_b && scan_found)
              scan_ptr_ff <= nxt_scan_ptr;
          end
        end
        ADCSQ_SAMPLE: begin
          if (tad_cnt_ff >= auto_sample_time) begin
            state_ff <= ADCSQ_CONV;
            tad_cnt_ff <= 5'h00;
            ch_idx_ff <= 2'd0;
          end else if (tad_en) begin
            tad_cnt_ff <= tad_cnt_ff + 5'h01;
          end
        end
        ADCSQ_CONV: begin
          if (tad_en && int'(tad_cnt_ff) == CONV_TAD - 1) begin
            tad_cnt_ff <= 5'h00;
            done_ff <= 1'b1;
            dma_ff.req <= 1'b1;
            dma_ff.addr <= 16'(dma_order_mode_ff ? order_addr
                                                 : scatter_addr);
            buf_ptr_ff <= buf_ptr_ff + 10'h001;
            if (ch_idx_ff == last_ch) begin
              state_ff <= ADCSQ_IDLE;
              alt_b_ff <= alternate_sample_mode ? !alt_b_ff : 1'b0;
              if (last_of_group) begin
                increment_rate_cnt_ff <= 4'h0;
                event_ff <= 1'b1;
                buf_ptr_ff <= 10'h000;
                half_ff <= split_buffer_mode ? !half_ff : 1'b0;
              end else begin
                increment_rate_cnt_ff <= increment_rate_cnt_ff + 4'h1;
              end
            end else begin
              ch_idx_ff <= ch_idx_ff + 2'd1;
            end
          end else if (tad_en) begin
            tad_cnt_ff <= tad_cnt_ff + 5'h01;
          end
        end
        default: state_ff <= ADCSQ_IDLE;
      endcase
    end
  end

  // aux channel inputs and mux outputs, registered
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      mux_ff <= '0;
    end else begin
      mux_ff.main_pos <= main_pos;
      mux_ff.main_neg <= main_neg;
      mux_ff.use_vref_neg <= main_absent;
      mux_ff.aux_pos_0 <= aux_pos_sel ? 5'd3 : 5'd0;
      mux_ff.aux_pos_1 <= aux_pos_sel ? 5'd4 : 5'd1;
      mux_ff.aux_pos_2 <= aux_pos_sel ? 5'd5 : 5'd2;
      mux_ff.aux_neg <= aux_neg_sel;  // 10 AN6-8, 11 AN9-11, 0x ref
      mux_ff.channel_count <= channel_count_select;
    end
  end

  assign mux_o          = mux_ff;
  assign sampling_o     = state_ff == ADCSQ_SAMPLE;
  assign convert_done_o = done_ff;
  assign event_o        = event_ff;
  assign dma_o          = dma_ff;
endmodule

// *** adcsq_properties.sv ***
// Purpose: port-level properties of the sequence and input select block
// Assumes: one clock, synchronous active-high reset
// Notes:   attached to adcsq_core by the bind below
`timescale 1ns/1ns
`include "adcsq_map.svh"
module adcsq_properties (
  input  wire logic                     mclk_i,
  input  wire logic                     sys_rst_i,
  input  wire logic [`ADCSQ_ADDR_W-1:0] reg_addr_i,
  input  wire logic                     reg_rd_i,
  input  wire logic [15:0]              reg_rdata_o,
  input  wire logic                     start_sample_i,
  input  wire logic                     module_disable_i,
  input  wire logic [15:0]              peer_pin_digital_select_low_i,
  input  wire logic                     sampling_o,
  input  wire logic                     convert_done_o,
  input  wire logic                     event_o,
  input  wire adcsq_pkg::adcsq_dma_type dma_o,
  input  wire logic [31:0]              pin_analog_o,
  input  wire logic [31:0]              port_read_en_o
);
  import adcsq_pkg::*;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  // read data only in the cycle after a read strobe
  a_rdata_quiet_zero: assert property (
    !$past(reg_rd_i) |-> reg_rdata_o == 16'h0000)
    else $error("read data seen without a read");
  a_unmapped_read_zero: assert property (
    $past(reg_rd_i) && $past(reg_addr_i) > 4'ha |-> reg_rdata_o == 16'h0000)
    else $error("unmapped read returned data");
  // pin mode and port read enable are opposite
  a_pin_mode_pair: assert property (
    pin_analog_o == ~port_read_en_o)
    else $error("pin analog and port read disagree");
  a_disable_digital: assert property (
    module_disable_i |-> pin_analog_o == 32'h0)
    else $error("disabled converter left a pin analog");
  a_peer_low_joint: assert property (
    !module_disable_i |-> (pin_analog_o[15:0] | peer_pin_digital_select_low_i) == 16'hffff)
    else $error("peer analog pin not analog");
  a_disable_no_start: assert property (
    module_disable_i && start_sample_i && !sampling_o |=> !sampling_o)
    else $error("sample started while disabled");
  // result pulses are single cycles
  a_done_single: assert property (
    convert_done_o |=> !convert_done_o)
    else $error("done pulse longer than one cycle");
  a_event_single: assert property (
    event_o |=> !event_o)
    else $error("event pulse longer than one cycle");
  a_dma_with_done: assert property (
    dma_o.req |-> convert_done_o)
    else $error("dma request without a conversion");
endmodule
bind adcsq_core adcsq_properties adcsq_properties_inst (
  .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .start_sample_i(start_sample_i), .module_disable_i(module_disable_i),
  .peer_pin_digital_select_low_i(peer_pin_digital_select_low_i), .sampling_o(sampling_o),
  .convert_done_o(convert_done_o), .event_o(event_o), .dma_o(dma_o),
  .pin_analog_o(pin_analog_o), .port_read_en_o(port_read_en_o));

// *** adcsq_partner.sv ***
// Purpose: far-side model: converter control start logic and RC clock
// Assumes: start request accepted only while the converter is idle
// Notes:   counts finished conversions for the bench
`timescale 1ns/1ns
module adcsq_partner (
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic go_i,
  input  wire logic sampling_i,
  input  wire logic done_i,
  output logic      start_o,
  output logic      rc_clock_o,
  output int        done_cnt_o
);
  logic pend_ff;
  logic busy_ff;
  // internal RC oscillator runs free at 4 MHz
  initial rc_clock_o = 1'b0;
  always #125 rc_clock_o = ~rc_clock_o;
  // one start pulse per request, held off while sampling and after a start until the next done or request
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      pend_ff <= 1'b0;
      busy_ff <= 1'b0;
      start_o <= 1'b0;
      done_cnt_o <= 0;
    end else begin
      start_o <= pend_ff && !busy_ff && !sampling_i && !start_o;
      if (go_i) pend_ff <= 1'b1;
      else if (start_o) pend_ff <= 1'b0;
      if (done_i || go_i) busy_ff <= 1'b0;
      else if (start_o) busy_ff <= 1'b1;
      if (done_i) done_cnt_o <= done_cnt_o + 1;
    end
  end
endmodule

// *** tb_adcsq_core.sv ***
// Purpose: self-checking bench of the sequence and input select block
// Assumes: register port with read data one cycle after the strobe
// Notes:   random register traffic plus sequencing corner cases
`timescale 1ns/1ns
`include "adcsq_map.svh"
module tb_adcsq_core;
  import adcsq_pkg::*;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic go = 1'b0, dis = 1'b0, start, rc, sampling_o, done, evt, cclk;
  logic [3:0] reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000, peer = 16'hffff, rdata, lo, hi, d;
  logic [31:0] pin_analog_o, port_rd;
  logic [4:0] last_pos;
  adcsq_mux_type mux_o;
  adcsq_dma_type dma;
  int err_total = 0, n_tests = 0, cyc = 0, done_n, evt_n = 0, i;
  always #50 mclk_i = ~mclk_i;
  adcsq_core adcsq_core_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr),
    .reg_rd_i(reg_rd), .reg_rdata_o(rdata), .start_sample_i(start),
    .module_disable_i(dis), .peer_pin_digital_select_low_i(peer), .rc_clock_i(rc),
    .mux_o(mux_o), .sampling_o(sampling_o), .conv_clk_en_o(cclk),
    .convert_done_o(done), .event_o(evt), .dma_o(dma),
    .pin_analog_o(pin_analog_o), .port_read_en_o(port_rd));
  adcsq_partner adcsq_partner_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
    .go_i(go), .sampling_i(sampling_o), .done_i(done), .start_o(start),
    .rc_clock_o(rc), .done_cnt_o(done_n));
  // watch input choice while sampling, count events, cut hangs
  always @(posedge mclk_i) begin
    if (sampling_o === 1'b1) last_pos <= mux_o.main_pos;
    if (evt === 1'b1) evt_n <= evt_n + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    if (err_total == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, e);
    n_tests++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // writable bits of each register, by index
  function automatic logic [15:0] wr_mask(input int a);
    case (a)
      0:       wr_mask = 16'h073f;
      1:       wr_mask = 16'h9fff;
      2:       wr_mask = 16'h0007;
      3:       wr_mask = 16'h0707;
      4:       wr_mask = 16'h9f9f;
      default: wr_mask = 16'hffff;
    endcase
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk_i);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk_i);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", {16'h0, rdata}, {16'h0, e});
  endtask
  task automatic one_sample(input logic [4:0] pos);
    int d0, k;
    d0 = done_n;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    for (k = 0; k < 3000 && done_n == d0; k++) @(posedge mclk_i);
    repeat (4) @(posedge mclk_i);
    #1;
    chk("main_pos", {27'h0, last_pos}, {27'h0, pos});
  endtask
  // cycles between conversion clock ticks for one divider value
  task automatic tad_period(input logic [7:0] dv);
    int n;
    n = 0;
    wr(4'h1, {8'h00, dv});
    while (cclk !== 1'b1 && n < 600) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    n = 0;
    do begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (cclk !== 1'b1 && n < 600);
    chk("tad_period", n, {24'h0, dv} + 32'd1);
  endtask
  initial begin
    void'($urandom(32'h3e6ca259));
    repeat (8) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    // reset values: all zero, scan pointer parked at its restart slot
    for (i = 0; i < 16; i++) begin
      rd(i[3:0], (i == 10) ? {11'h000, `ADCSQ_SCAN_PTR_RST}
                           : 16'h0000);
    end
    // random traffic against the write masks
    for (i = 0; i < 36; i++) begin
      d = $urandom;
      wr(i % 9, d);
      rd(i % 9, d & wr_mask(i % 9));
    end
    wr(4'hc, 16'hffff);
    rd(4'hc, 16'h0000);
    // twelve-bit mode hides channel count and aux selects
    wr(4'h9, 16'h0001);
    wr(4'h0, 16'hffff);
    rd(4'h0, 16'h043f);
    wr(4'h3, 16'hffff);
    rd(4'h3, 16'h0000);
    wr(4'h9, 16'h0000);
    // pin modes, peer register and module disable
    lo = $urandom;
    hi = $urandom;
    wr(4'h8, lo);
    wr(4'h7, hi);
    chk("pin_analog", pin_analog_o, ~{hi, lo});
    peer <= $urandom;
    @(posedge mclk_i);
    #1;
    chk("pin_analog_lo", {16'h0, pin_analog_o[15:0]},
        {16'h0, ~lo | ~peer});
    dis <= 1'b1;
    go <= 1'b1;
    @(posedge mclk_i);
    go <= 1'b0;
    repeat (40) @(posedge mclk_i);
    #1;
    chk("disabled_pins", pin_analog_o, 32'h0);
    chk("disabled_done", done_n, 0);
    dis <= 1'b0;
    peer <= 16'hffff;
    wr(4'h8, 16'h0000);
    wr(4'h7, 16'h0000);
    // alternate A/B, event every second sample, split buffer halves
    wr(4'h1, 16'h0201);
    wr(4'h4, 16'h0905);
    wr(4'h0, 16'h0007);
    one_sample(5'd5);
    one_sample(5'd9);
    rd(4'h0, 16'h0087);
    one_sample(5'd5);
    one_sample(5'd9);
    rd(4'h0, 16'h0007);
    chk("event_count", evt_n, 2);
    // scan through mask bits 3 and 7
    wr(4'h6, 16'h0088);
    wr(4'h5, 16'h0000);
    wr(4'h0, 16'h0400);
    one_sample(5'd3);
    one_sample(5'd7);
    one_sample(5'd3);
    wr(4'h1, 16'h8201);
    one_sample(5'd7);
    chk("done_count", done_n, 8);
    // conversion clock period: random divider, then the 64-cycle case
    tad_period(8'($urandom % 10));
    tad_period(8'h3f);
    // aux channel inputs for sample A
    wr(4'h3, 16'h0501);
    @(posedge mclk_i);
    #1;
    chk("aux_pos_0", {27'h0, mux_o.aux_pos_0}, 32'd3);
    chk("aux_neg", {30'h0, mux_o.aux_neg}, 32'h0);
    wr(4'h3, 16'h0004);
    @(posedge mclk_i);
    #1;
    chk("aux_pos_2", {27'h0, mux_o.aux_pos_2}, 32'd2);
    chk("aux_neg", {30'h0, mux_o.aux_neg}, 32'h2);
    // two channels per sample when the count field is 01, scan off
    wr(4'h1, 16'h0000);
    wr(4'h0, 16'h0100);
    one_sample(5'd5);
    repeat (20) @(posedge mclk_i);
    #1;
    chk("channel_count", {30'h0, mux_o.channel_count}, 32'h1);
    chk("done_count", done_n, 10);
    report_and_stop();
  end
endmodule
